/* File: pkg/ccs_pkg.sv */
package ccs_pkg;
  // Bus and cache geometry.
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int OFF_W = 4;
  localparam int SET_W = 6;
  localparam int TAG_W = ADDR_W - OFF_W - SET_W;
  localparam int PAGE_LSB = 12;
  localparam int PAGE_TAG_LSB = PAGE_LSB - OFF_W - SET_W;
  localparam int ENT_W = TAG_W + 2;
  localparam int V_BIT = TAG_W + 1;
  localparam int D_BIT = TAG_W;
  localparam logic [SET_W-1:0] LAST_SET = 6'h3f;

  // Control register select and layout.
  localparam logic CTL_SEL_CACHE = 1'h0;
  localparam logic CTL_SEL_WINDOW = 1'h1;
  localparam int CACR_DCE_BIT = 31;
  localparam int CACR_ICE_BIT = 15;
  localparam logic [DATA_W-1:0] CACR_MASK = 32'h8000_8000;
  localparam logic [DATA_W-1:0] CACR_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] DTT_RESET = 32'h0000_0000;

  // Transparent window fields.
  localparam int DTT_BASE_LSB = 24;
  localparam int DTT_MASK_LSB = 16;
  localparam int DTT_EN_BIT = 15;
  localparam int DTT_S_HI = 14;
  localparam int DTT_S_LO = 13;
  localparam int DTT_CM_HI = 6;
  localparam int DTT_CM_LO = 5;
  localparam logic [1:0] CM_INHIBIT_SERIAL = 2'h2;
  localparam logic [1:0] CM_INHIBIT_PLAIN = 2'h3;

  // Snoop control codes.
  localparam logic [1:0] SC_NONE = 2'h0;
  localparam logic [1:0] SC_SUPPLY = 2'h1;
  localparam logic [1:0] SC_INVAL = 2'h2;

  // Bus masters other than this processor.
  localparam logic [1:0] MST_CPU = 2'h0;
  localparam logic [1:0] MST_VME = 2'h1;
  localparam logic [1:0] MST_DMA = 2'h2;

  // Transfer type codes.
  localparam logic [1:0] TT_NORMAL = 2'h0;
  localparam logic [1:0] TT_LINE_MOVE = 2'h1;
  localparam logic [1:0] TT_ALTERNATE = 2'h2;
  localparam logic [1:0] TT_IACK = 2'h3;
  localparam logic [2:0] FC_ALT0 = 3'h0;
  localparam logic [2:0] FC_ALT3 = 3'h3;
  localparam logic [2:0] FC_ALT4 = 3'h4;
  localparam logic [2:0] FC_ALT7 = 3'h7;

  // Cache maintenance operations.
  localparam logic OP_INVALIDATE = 1'h0;
  localparam logic OP_PUSH = 1'h1;
  localparam logic [1:0] SCOPE_LINE = 2'h0;
  localparam logic [1:0] SCOPE_PAGE = 2'h1;
  localparam logic [1:0] SCOPE_ALL = 2'h2;

  typedef enum {SN_IDLE, SN_LOOK} ccs_snoop_state_type;
  typedef enum {WK_IDLE, WK_READ, WK_CHECK, WK_PUSH, WK_CLEAR} ccs_walk_state_type;
endpackage : ccs_pkg

/* File: hw/ccs_tag_mem.sv */
`timescale 1ns/1ps
module ccs_tag_mem
  import ccs_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_we,
  input wire logic [SET_W-1:0] i_waddr,
  input wire logic [ENT_W-1:0] i_wdata,
  input wire logic [SET_W-1:0] i_raddr,
  output logic [ENT_W-1:0] o_rdata
);
  logic [ENT_W-1:0] mem [0:(1<<SET_W)-1];

  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    o_rdata <= mem[i_raddr];
  end
endmodule : ccs_tag_mem

/* File: hw/ccs_snoop.sv */
`timescale 1ns/1ps
module ccs_snoop
  import ccs_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_ctl_wr,
  input wire logic i_ctl_sel,
  input wire logic [DATA_W-1:0] i_ctl_wdata,
  output logic [DATA_W-1:0] o_ctl_rdata,
  input wire logic i_snoop_enable,
  input wire logic i_vme_slave_snoop_enable,
  input wire logic i_module_dma_snoop_enable,
  input wire logic i_module_snoop_request_n,
  input wire logic i_bus_req,
  input wire logic [ADDR_W-1:0] i_bus_addr,
  input wire logic i_bus_write,
  input wire logic [1:0] i_bus_master,
  input wire logic i_bus_block,
  input wire logic [1:0] i_snoop_control_code,
  output logic o_mem_hold,
  output logic o_snoop_done,
  output logic o_mem_inhibit,
  output logic o_supply_data,
  input wire logic i_cpu_req,
  input wire logic i_cpu_icache,
  input wire logic i_cpu_dirty,
  input wire logic i_cpu_super,
  input wire logic [ADDR_W-1:0] i_cpu_addr,
  output logic o_cpu_grant,
  output logic o_window_noncache,
  output logic o_window_serial,
  input wire logic i_op_req,
  input wire logic i_op_kind,
  input wire logic [1:0] i_op_scope,
  input wire logic [ADDR_W-1:0] i_op_addr,
  output logic o_op_busy,
  output logic o_push_req,
  output logic [ADDR_W-1:0] o_push_addr,
  input wire logic i_push_ack,
  input wire logic i_xfer_line_move,
  input wire logic i_xfer_iack,
  input wire logic [2:0] i_xfer_fc,
  output logic o_transfer_type_hi,
  output logic o_transfer_type_lo,
  output logic o_dcache_en,
  output logic o_icache_en
);
  function automatic logic [1:0] snoop_code(input logic [1:0] master, input logic wr,
      input logic blk, input logic [1:0] cpu_sc, input logic vme_en, input logic dma_on,
      input logic glb_en);
    logic [1:0] rw_code;
    rw_code = wr ? SC_INVAL : SC_SUPPLY;
    snoop_code = SC_NONE;
    if (!glb_en || blk) begin
      snoop_code = SC_NONE;
    end else if (master == MST_CPU) begin
      snoop_code = cpu_sc;
    end else if (master == MST_VME) begin
      snoop_code = vme_en ? rw_code : SC_NONE;
    end else if (master == MST_DMA) begin
      snoop_code = dma_on ? rw_code : SC_NONE;
    end
  endfunction : snoop_code
  function automatic logic tag_match(input logic [ENT_W-1:0] ent, input logic [TAG_W-1:0] tag,
      input logic [1:0] scope);
    tag_match = 1'h1;
    if (scope == SCOPE_LINE) begin
      tag_match = ent[V_BIT] && (ent[TAG_W-1:0] == tag);
    end else if (scope == SCOPE_PAGE) begin
      tag_match = ent[V_BIT] && (ent[TAG_W-1:PAGE_TAG_LSB] == tag[TAG_W-1:PAGE_TAG_LSB]);
    end
  endfunction : tag_match
  logic [DATA_W-1:0] cache_enable_control, data_transparent_window_0;
  ccs_snoop_state_type sn_state;
  ccs_walk_state_type wk_state;
  logic [ADDR_W-1:0] sn_addr;
  logic [ENT_W-1:0] d_rdata, i_rdata, wr_data;
  logic [SET_W-1:0] rd_addr, wr_addr, wk_idx;
  logic [TAG_W-1:0] wk_tag;
  logic [1:0] sn_code, wk_scope, win_cm;
  logic [7:0] win_mask;
  logic req_n_meta, req_n_sync, sn_write, d_we, i_we, sn_start, sn_look, cpu_go;
  logic wk_kind, wk_imatch, d_hit, i_hit, wd_match, wi_match, wk_last, win_hit;
  // Module request is a pin from another domain.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      req_n_meta <= 1'h1;
      req_n_sync <= 1'h1;
    end else begin
      req_n_meta <= i_module_snoop_request_n;
      req_n_sync <= req_n_meta;
    end
  end
  assign sn_code = snoop_code(i_bus_master, i_bus_write, i_bus_block, i_snoop_control_code,
      i_vme_slave_snoop_enable, i_module_dma_snoop_enable || !req_n_sync, i_snoop_enable);
  assign sn_start = (sn_state == SN_IDLE) && i_bus_req &&
      ((sn_code == SC_INVAL) || (sn_code == SC_SUPPLY));
  assign sn_look = (sn_state == SN_LOOK);
  assign d_hit = d_rdata[V_BIT] && (d_rdata[TAG_W-1:0] == sn_addr[ADDR_W-1:OFF_W+SET_W]);
  assign i_hit = i_rdata[V_BIT] && (i_rdata[TAG_W-1:0] == sn_addr[ADDR_W-1:OFF_W+SET_W]);
  assign cpu_go = i_cpu_req && (sn_state == SN_IDLE) && !i_bus_req && (wk_state == WK_IDLE);
  assign wd_match = tag_match(d_rdata, wk_tag, wk_scope);
  assign wi_match = tag_match(i_rdata, wk_tag, wk_scope);
  assign wk_last = (wk_scope == SCOPE_LINE) || (wk_idx == LAST_SET);
  // Snoop read has the tag arrays first.
  assign rd_addr = (sn_state == SN_IDLE && i_bus_req) ?
      i_bus_addr[OFF_W+SET_W-1:OFF_W] : wk_idx;
  // Write port arbitration: snoop, then maintenance, then execution units.
  always_comb begin
    d_we = 1'h0;
    i_we = 1'h0;
    wr_addr = wk_idx;
    wr_data = '0;
    if (sn_look) begin
      wr_addr = sn_addr[OFF_W+SET_W-1:OFF_W];
      d_we = sn_write && d_hit;
      i_we = sn_write && i_hit;
    end else if (wk_state == WK_CHECK) begin
      d_we = wd_match && !(wk_kind == OP_PUSH && d_rdata[D_BIT]);
      i_we = wi_match;
    end else if (wk_state == WK_CLEAR) begin
      d_we = 1'h1;
      i_we = wk_imatch;
    end else if (cpu_go) begin
      wr_addr = i_cpu_addr[OFF_W+SET_W-1:OFF_W];
      wr_data = {1'h1, i_cpu_dirty, i_cpu_addr[ADDR_W-1:OFF_W+SET_W]};
      d_we = !i_cpu_icache && cache_enable_control[CACR_DCE_BIT];
      i_we = i_cpu_icache && cache_enable_control[CACR_ICE_BIT];
    end
  end
  ccs_tag_mem u_dtag (
    .i_ref_clk(i_ref_clk),
    .i_we(d_we),
    .i_waddr(wr_addr),
    .i_wdata(wr_data),
    .i_raddr(rd_addr),
    .o_rdata(d_rdata)
  );
  ccs_tag_mem u_itag (
    .i_ref_clk(i_ref_clk),
    .i_we(i_we),
    .i_waddr(wr_addr),
    .i_wdata(wr_data),
    .i_raddr(rd_addr),
    .o_rdata(i_rdata)
  );
  // Control registers.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      cache_enable_control <= CACR_RESET;
      data_transparent_window_0 <= DTT_RESET;
    end else if (i_ctl_wr && i_ctl_sel == CTL_SEL_CACHE) begin
      cache_enable_control <= i_ctl_wdata & CACR_MASK;
    end else if (i_ctl_wr && i_ctl_sel == CTL_SEL_WINDOW) begin
      data_transparent_window_0 <= i_ctl_wdata;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_ctl_rdata <= '0;
      o_dcache_en <= 1'h0;
      o_icache_en <= 1'h0;
    end else begin
      o_ctl_rdata <= (i_ctl_sel == CTL_SEL_WINDOW) ? data_transparent_window_0 :
          cache_enable_control;
      o_dcache_en <= cache_enable_control[CACR_DCE_BIT];
      o_icache_en <= cache_enable_control[CACR_ICE_BIT];
    end
  end
  // Transparent window match on the processor address.
  assign win_mask = data_transparent_window_0[DTT_MASK_LSB+7:DTT_MASK_LSB];
  assign win_cm = data_transparent_window_0[DTT_CM_HI:DTT_CM_LO];
  assign win_hit = data_transparent_window_0[DTT_EN_BIT] &&
      ((i_cpu_addr[ADDR_W-1:DTT_BASE_LSB] | win_mask) ==
      (data_transparent_window_0[ADDR_W-1:DTT_BASE_LSB] | win_mask)) &&
      (data_transparent_window_0[DTT_S_HI] ||
      (data_transparent_window_0[DTT_S_LO] == i_cpu_super));
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_window_noncache <= 1'h0;
      o_window_serial <= 1'h0;
    end else begin
      o_window_noncache <= win_hit && (win_cm == CM_INHIBIT_SERIAL || win_cm == CM_INHIBIT_PLAIN);
      o_window_serial <= win_hit && (win_cm == CM_INHIBIT_SERIAL);
    end
  end
  // Transfer type encoding.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      {o_transfer_type_hi, o_transfer_type_lo} <= TT_NORMAL;
    end else if (i_xfer_iack) begin
      {o_transfer_type_hi, o_transfer_type_lo} <= TT_IACK;
    end else if (i_xfer_line_move) begin
      {o_transfer_type_hi, o_transfer_type_lo} <= TT_LINE_MOVE;
    end else if (i_xfer_fc == FC_ALT0 || i_xfer_fc == FC_ALT3 || i_xfer_fc == FC_ALT4 ||
        i_xfer_fc == FC_ALT7) begin
      {o_transfer_type_hi, o_transfer_type_lo} <= TT_ALTERNATE;
    end else begin
      {o_transfer_type_hi, o_transfer_type_lo} <= TT_NORMAL;
    end
  end

  // Snoop sequencer.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      sn_state <= SN_IDLE;
      sn_addr <= '0;
      sn_write <= 1'h0;
      o_mem_hold <= 1'h0;
      o_snoop_done <= 1'h0;
      o_mem_inhibit <= 1'h0;
      o_supply_data <= 1'h0;
    end else begin
      o_snoop_done <= 1'h0;
      o_mem_inhibit <= 1'h0;
      o_supply_data <= 1'h0;
      case (sn_state)
        SN_IDLE: begin
          if (sn_start) begin
            sn_addr <= i_bus_addr;
            sn_write <= i_bus_write;
            o_mem_hold <= 1'h1;
            sn_state <= SN_LOOK;
          end else if (i_bus_req) begin
            o_snoop_done <= 1'h1;
          end
        end
        SN_LOOK: begin
          o_mem_hold <= 1'h0;
          o_snoop_done <= 1'h1;
          o_mem_inhibit <= !sn_write && d_hit && d_rdata[D_BIT];
          o_supply_data <= !sn_write && d_hit && d_rdata[D_BIT];
          sn_state <= SN_IDLE;
        end
        default: begin
          sn_state <= SN_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_cpu_grant <= 1'h0;
    end else begin
      o_cpu_grant <= cpu_go;
    end
  end

  // Invalidate and push walker.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      wk_state <= WK_IDLE;
      wk_kind <= OP_INVALIDATE;
      wk_scope <= SCOPE_LINE;
      wk_tag <= '0;
      wk_idx <= '0;
      wk_imatch <= 1'h0;
      o_op_busy <= 1'h0;
      o_push_req <= 1'h0;
      o_push_addr <= '0;
    end else begin
      case (wk_state)
        WK_IDLE: begin
          if (i_op_req) begin
            wk_kind <= i_op_kind;
            wk_scope <= i_op_scope;
            wk_tag <= i_op_addr[ADDR_W-1:OFF_W+SET_W];
            wk_idx <= (i_op_scope == SCOPE_LINE) ? i_op_addr[OFF_W+SET_W-1:OFF_W] : '0;
            o_op_busy <= 1'h1;
            wk_state <= WK_READ;
          end
        end
        WK_READ: begin
          if (!(sn_state == SN_IDLE && i_bus_req)) begin
            wk_state <= WK_CHECK;
          end
        end
        WK_CHECK: begin
          if (sn_look) begin
            wk_state <= WK_READ;
          end else if (wk_kind == OP_PUSH && wd_match && d_rdata[D_BIT]) begin
            o_push_req <= 1'h1;
            o_push_addr <= {d_rdata[TAG_W-1:0], wk_idx, {OFF_W{1'b0}}};
            wk_imatch <= wi_match;
            wk_state <= WK_PUSH;
          end else if (wk_last) begin
            o_op_busy <= 1'h0;
            wk_state <= WK_IDLE;
          end else begin
            wk_idx <= wk_idx + 1'b1;
            wk_state <= WK_READ;
          end
        end
        WK_PUSH: begin
          if (i_push_ack) begin
            o_push_req <= 1'h0;
            wk_state <= WK_CLEAR;
          end
        end
        WK_CLEAR: begin
          if (!sn_look && wk_last) begin
            o_op_busy <= 1'h0;
            wk_state <= WK_IDLE;
          end else if (!sn_look) begin
            wk_idx <= wk_idx + 1'b1;
            wk_state <= WK_READ;
          end
        end
        default: begin
          wk_state <= WK_IDLE;
        end
      endcase
    end
  end
endmodule : ccs_snoop

/* File: testbench/ccs_snoop_props.sv */
`timescale 1ns/1ps
module ccs_snoop_props
  import ccs_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_ctl_wr,
  input wire logic i_ctl_sel,
  input wire logic [DATA_W-1:0] i_ctl_wdata,
  input wire logic i_snoop_enable,
  input wire logic i_bus_req,
  input wire logic i_bus_block,
  input wire logic i_cpu_req,
  input wire logic i_push_ack,
  input wire logic i_xfer_iack,
  input wire logic o_mem_hold,
  input wire logic o_snoop_done,
  input wire logic o_mem_inhibit,
  input wire logic o_supply_data,
  input wire logic o_cpu_grant,
  input wire logic o_push_req,
  input wire logic [ADDR_W-1:0] o_push_addr,
  input wire logic o_transfer_type_hi,
  input wire logic o_transfer_type_lo,
  input wire logic o_dcache_en,
  input wire logic o_icache_en
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  property p_hold_release;
    o_mem_hold |=> !o_mem_hold && o_snoop_done;
  endproperty
  a_hold_release: assert property (p_hold_release) else $error("hold not released");

  property p_cache_bits;
    i_ctl_wr && i_ctl_sel == CTL_SEL_CACHE |-> ##2
      o_dcache_en == $past(i_ctl_wdata[CACR_DCE_BIT], 2) &&
      o_icache_en == $past(i_ctl_wdata[CACR_ICE_BIT], 2);
  endproperty
  a_cache_bits: assert property (p_cache_bits) else $error("cache enable wrong");

  property p_snoop_first;
    i_cpu_req && i_bus_req |=> !o_cpu_grant;
  endproperty
  a_snoop_first: assert property (p_snoop_first) else $error("fill beat snoop");

  property p_inhibit_pair;
    o_mem_inhibit |-> o_snoop_done && o_supply_data && $past(o_mem_hold);
  endproperty
  a_inhibit_pair: assert property (p_inhibit_pair) else $error("inhibit alone");

  property p_global_off;
    i_bus_req && !i_snoop_enable && !o_mem_hold |=> o_snoop_done && !o_mem_hold;
  endproperty
  a_global_off: assert property (p_global_off) else $error("snoop while off");

  property p_block_pass;
    i_bus_req && i_bus_block && !o_mem_hold |=> o_snoop_done && !o_mem_hold;
  endproperty
  a_block_pass: assert property (p_block_pass) else $error("block snooped");

  property p_push_wait;
    o_push_req && !i_push_ack |=> o_push_req && $stable(o_push_addr);
  endproperty
  a_push_wait: assert property (p_push_wait) else $error("push dropped");

  property p_iack_code;
    i_xfer_iack |=> o_transfer_type_hi && o_transfer_type_lo;
  endproperty
  a_iack_code: assert property (p_iack_code) else $error("iack code wrong");
endmodule : ccs_snoop_props

bind ccs_snoop ccs_snoop_props u_props (.i_ref_clk, .i_sys_rst, .i_ctl_wr, .i_ctl_sel,
  .i_ctl_wdata, .i_snoop_enable, .i_bus_req, .i_bus_block, .i_cpu_req, .i_push_ack,
  .i_xfer_iack, .o_mem_hold, .o_snoop_done, .o_mem_inhibit, .o_supply_data, .o_cpu_grant,
  .o_push_req, .o_push_addr, .o_transfer_type_hi, .o_transfer_type_lo, .o_dcache_en,
  .o_icache_en);

/* File: testbench/ccs_bus_model.sv */
`timescale 1ns/1ps
module ccs_bus_model (
  input wire logic i_ref_clk,
  input wire logic i_push_req,
  input wire logic i_want_snoop,
  input wire logic [3:0] i_delay,
  output logic o_push_ack,
  output logic o_module_snoop_request_n
);
  logic [3:0] wait_count = 4'h0;
  initial o_push_ack = 1'b0;
  // The module flags its own cycles as snoopable on an active-low line.
  assign o_module_snoop_request_n = !i_want_snoop;
  // Memory takes the written-back line after a chosen delay.
  always @(posedge i_ref_clk) begin
    if (o_push_ack) begin
      o_push_ack <= 1'b0;
      wait_count <= 4'h0;
    end else if (i_push_req) begin
      if (wait_count == i_delay) o_push_ack <= 1'b1;
      else wait_count <= wait_count + 4'h1;
    end
  end
endmodule : ccs_bus_model

/* File: testbench/ccs_snoop_bench.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module ccs_snoop_bench
  import ccs_pkg::*;
;
  logic i_ref_clk, i_sys_rst, i_ctl_wr, i_ctl_sel, i_snoop_enable, i_vme_slave_snoop_enable;
  logic i_module_dma_snoop_enable, i_module_snoop_request_n, i_bus_req, i_bus_write;
  logic i_bus_block, i_cpu_req, i_cpu_icache, i_cpu_dirty, i_cpu_super, i_op_req, i_op_kind;
  logic i_push_ack, i_xfer_line_move, i_xfer_iack, want_snoop;
  logic [1:0] i_bus_master, i_snoop_control_code, i_op_scope, got_exp;
  logic [2:0] i_xfer_fc;
  logic [3:0] ack_delay;
  logic [31:0] i_ctl_wdata, i_bus_addr, i_cpu_addr, i_op_addr, base, push_seen;
  logic [31:0] o_ctl_rdata, o_push_addr;
  logic o_mem_hold, o_snoop_done, o_mem_inhibit, o_supply_data, o_cpu_grant, o_op_busy;
  logic o_window_noncache, o_window_serial, o_push_req, o_transfer_type_hi;
  logic o_transfer_type_lo, o_dcache_en, o_icache_en;
  logic [1:0] exp_q[$];
  logic [2:0] alt[4] = '{FC_ALT0, FC_ALT3, FC_ALT4, FC_ALT7};
  int err_total = 0;
  int cmp_count = 0;
  int seed = 32'hb7cd;

  ccs_snoop DUT (.i_ref_clk, .i_sys_rst, .i_ctl_wr, .i_ctl_sel, .i_ctl_wdata, .o_ctl_rdata,
    .i_snoop_enable, .i_vme_slave_snoop_enable, .i_module_dma_snoop_enable,
    .i_module_snoop_request_n, .i_bus_req, .i_bus_addr, .i_bus_write, .i_bus_master,
    .i_bus_block, .i_snoop_control_code, .o_mem_hold, .o_snoop_done, .o_mem_inhibit,
    .o_supply_data, .i_cpu_req, .i_cpu_icache, .i_cpu_dirty, .i_cpu_super, .i_cpu_addr,
    .o_cpu_grant, .o_window_noncache, .o_window_serial, .i_op_req, .i_op_kind, .i_op_scope,
    .i_op_addr, .o_op_busy, .o_push_req, .o_push_addr, .i_push_ack, .i_xfer_line_move,
    .i_xfer_iack, .i_xfer_fc, .o_transfer_type_hi, .o_transfer_type_lo, .o_dcache_en,
    .o_icache_en);
  ccs_bus_model partner (.i_ref_clk, .i_push_req(o_push_req), .i_want_snoop(want_snoop),
    .i_delay(ack_delay), .o_push_ack(i_push_ack),
    .o_module_snoop_request_n(i_module_snoop_request_n));

  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  task end_sim;
    $display("Counts: %0d compared, %0d mismatched", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  function automatic logic [31:0] la(input logic [5:0] s);
    return {base[31:10], s, base[3:0]};
  endfunction : la

  task automatic ctl(input logic s, input logic [31:0] d);
    i_ctl_wr = 1'b1;
    i_ctl_sel = s;
    i_ctl_wdata = d;
    @(negedge i_ref_clk);
    i_ctl_wr = 1'b0;
    repeat (2) @(negedge i_ref_clk);
  endtask : ctl

  task automatic fill(input logic [31:0] a, input logic ic, input logic dt);
    int k;
    k = 0;
    i_cpu_req = 1'b1;
    i_cpu_addr = a;
    i_cpu_icache = ic;
    i_cpu_dirty = dt;
    do begin
      @(negedge i_ref_clk);
      k++;
    end while (o_cpu_grant !== 1'b1 && k < 20);
    i_cpu_req = 1'b0;
    `CHK("fill grant", 1'b1, o_cpu_grant)
  endtask : fill

  task automatic snoop(input logic [1:0] m, input logic w, input logic b,
                       input logic [1:0] c, input logic [31:0] a, input logic e);
    int k;
    k = 0;
    exp_q.push_back({e, e});
    i_bus_req = 1'b1;
    i_bus_master = m;
    i_bus_write = w;
    i_bus_block = b;
    i_snoop_control_code = c;
    i_bus_addr = a;
    @(negedge i_ref_clk);
    i_bus_req = 1'b0;
    while (o_snoop_done !== 1'b1 && k < 10) begin
      @(negedge i_ref_clk);
      k++;
    end
    @(negedge i_ref_clk);
  endtask : snoop

  task automatic op(input logic k, input logic [1:0] s, input logic [31:0] a);
    int t;
    t = 0;
    i_op_req = 1'b1;
    i_op_kind = k;
    i_op_scope = s;
    i_op_addr = a;
    @(negedge i_ref_clk);
    i_op_req = 1'b0;
    while (o_op_busy === 1'b1 && t < 2000) begin
      @(negedge i_ref_clk);
      t++;
    end
    `CHK("op busy", 1'b0, o_op_busy)
  endtask : op

  task automatic tt(input logic m, input logic q, input logic [2:0] f, input logic [1:0] e);
    i_xfer_line_move = m;
    i_xfer_iack = q;
    i_xfer_fc = f;
    @(negedge i_ref_clk);
    `CHK("transfer type", e, {o_transfer_type_hi, o_transfer_type_lo})
  endtask : tt

  // Each answered cycle is matched against the oldest expected outcome.
  always @(negedge i_ref_clk) begin
    if (o_push_req === 1'b1) push_seen = o_push_addr;
    if (o_snoop_done === 1'b1) begin
      got_exp = (exp_q.size() == 0) ? 2'h3 : exp_q.pop_front();
      `CHK("inhibit supply", got_exp, {o_mem_inhibit, o_supply_data})
    end
  end

  initial begin
    {i_ctl_wr, i_ctl_sel, i_ctl_wdata, i_snoop_enable, i_vme_slave_snoop_enable,
     i_module_dma_snoop_enable, i_bus_req, i_bus_addr, i_bus_write, i_bus_master, i_bus_block,
     i_snoop_control_code, i_cpu_req, i_cpu_icache, i_cpu_dirty, i_cpu_super, i_cpu_addr,
     i_op_req, i_op_kind, i_op_scope, i_op_addr, i_xfer_line_move, i_xfer_iack, i_xfer_fc,
     want_snoop, push_seen} = '0;
    ack_delay = 4'h3;
    i_sys_rst = 1'b1;
    base = $random(seed);
    repeat (2) @(negedge i_ref_clk);
    i_sys_rst = 1'b0;
    op(OP_INVALIDATE, SCOPE_ALL, 32'h0);
    ctl(CTL_SEL_CACHE, 32'hffff_ffff);
    `CHK("cache reg", 32'h8000_8000, o_ctl_rdata)
    `CHK("cache en", 2'h3, {o_dcache_en, o_icache_en})
    ctl(CTL_SEL_WINDOW, 32'hfe01_a040);
    i_cpu_addr = 32'hff12_3450;
    @(negedge i_ref_clk);
    `CHK("window user", 2'h0, {o_window_noncache, o_window_serial})
    i_cpu_super = 1'b1;
    @(negedge i_ref_clk);
    `CHK("window super", 2'h3, {o_window_noncache, o_window_serial})
    ctl(CTL_SEL_WINDOW, 32'hfe01_c040);
    `CHK("window reg", 32'hfe01_c040, o_ctl_rdata)
    i_cpu_addr = 32'hff12_3450;
    @(negedge i_ref_clk);
    `CHK("window hit", 2'h3, {o_window_noncache, o_window_serial})
    i_cpu_addr = 32'hfd00_0000;
    @(negedge i_ref_clk);
    `CHK("window miss", 2'h0, {o_window_noncache, o_window_serial})
    i_snoop_enable = 1'b1;
    i_vme_slave_snoop_enable = 1'b1;
    fill(la(6'h1), 1'b0, 1'b1);
    snoop(MST_VME, 1'b0, 1'b0, SC_NONE, la(6'h1), 1'b1);
    i_vme_slave_snoop_enable = 1'b0;
    snoop(MST_VME, 1'b0, 1'b0, SC_NONE, la(6'h1), 1'b0);
    i_vme_slave_snoop_enable = 1'b1;
    snoop(MST_DMA, 1'b0, 1'b0, SC_NONE, la(6'h1), 1'b0);
    want_snoop = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    snoop(MST_DMA, 1'b0, 1'b0, SC_NONE, la(6'h1), 1'b1);
    want_snoop = 1'b0;
    i_module_dma_snoop_enable = 1'b1;
    snoop(MST_DMA, 1'b0, 1'b0, SC_NONE, la(6'h1), 1'b1);
    i_snoop_enable = 1'b0;
    snoop(MST_VME, 1'b0, 1'b0, SC_NONE, la(6'h1), 1'b0);
    i_snoop_enable = 1'b1;
    snoop(MST_VME, 1'b0, 1'b1, SC_NONE, la(6'h1), 1'b0);
    snoop(MST_CPU, 1'b0, 1'b0, SC_SUPPLY, la(6'h1), 1'b1);
    fill(la(6'h2), 1'b0, 1'b0);
    snoop(MST_VME, 1'b0, 1'b0, SC_NONE, la(6'h2), 1'b0);
    fill(la(6'h3), 1'b1, 1'b1);
    snoop(MST_VME, 1'b0, 1'b0, SC_NONE, la(6'h3), 1'b0);
    snoop(MST_VME, 1'b1, 1'b0, SC_NONE, la(6'h1), 1'b0);
    snoop(MST_VME, 1'b0, 1'b0, SC_NONE, la(6'h1), 1'b0);
    fill(la(6'h6), 1'b0, 1'b1);
    snoop(MST_CPU, 1'b1, 1'b0, SC_INVAL, la(6'h6), 1'b0);
    snoop(MST_VME, 1'b0, 1'b0, SC_NONE, la(6'h6), 1'b0);
    fork
      fill(la(6'h4), 1'b0, 1'b1);
      snoop(MST_VME, 1'b0, 1'b0, SC_NONE, la(6'h2), 1'b0);
    join
    op(OP_PUSH, SCOPE_LINE, la(6'h4));
    `CHK("push addr", {base[31:10], 6'h4, 4'h0}, push_seen)
    snoop(MST_VME, 1'b0, 1'b0, SC_NONE, la(6'h4), 1'b0);
    ctl(CTL_SEL_CACHE, 32'h0);
    `CHK("cache off", 2'h0, {o_dcache_en, o_icache_en})
    fill(la(6'h5), 1'b0, 1'b1);
    snoop(MST_VME, 1'b0, 1'b0, SC_NONE, la(6'h5), 1'b0);
    tt(1'b0, 1'b0, 3'h1, TT_NORMAL);
    tt(1'b1, 1'b0, 3'h1, TT_LINE_MOVE);
    tt(1'b1, 1'b1, 3'h1, TT_IACK);
    foreach (alt[j]) tt(1'b0, 1'b0, alt[j], TT_ALTERNATE);
    end_sim();
  end

  initial begin
    #100000;
    err_total++;
    end_sim();
  end
endmodule : ccs_snoop_bench
